/* logic/loop_gain_and_leg_telemetry_regs.sv */
// Loop gain configuration and per-leg telemetry command registers
`timescale 1ns/1ps

module loop_gain_and_leg_telemetry_regs #(
	parameter int NUM_LEGS = 4,
	parameter int LEG_SEL_W = 2
) (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_cmd_valid,
	input wire loop_gain_regs_pkg::cmd_req_t i_cmd,
	input wire logic [LEG_SEL_W-1:0] i_leg_select,
	input wire logic [NUM_LEGS-1:0][15:0] i_leg_current,
	input wire logic [NUM_LEGS-1:0][15:0] i_leg_temperature,
	input wire logic [15:0] i_prop_gain_word,
	input wire logic i_one_leg_active,
	input wire logic [15:0] i_bus_current,
	output logic o_rsp_valid,
	output loop_gain_regs_pkg::cmd_rsp_t o_rsp,
	output loop_gain_regs_pkg::deriv_gain_t o_deriv_gain,
	output logic [7:0] o_hpf_coef,
	output logic [7:0] o_cfb_gain,
	output logic [15:0] o_scale_factor,
	output logic [15:0] o_scaled_current
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] masked_write(
		input logic [15:0] old_val,
		input logic [15:0] new_val,
		input logic [15:0] mask
	);
		masked_write = (old_val & ~mask) | (new_val & mask);
	endfunction : masked_write

	function automatic logic signed [4:0] deriv_shift(
		input logic [1:0] d_exp,
		input logic [2:0] p_exp
	);
		deriv_shift = $signed({3'h0, d_exp}) + loop_gain_regs_pkg::DG_EXP_BIAS
			+ $signed({2'h0, p_exp}) - loop_gain_regs_pkg::PG_EXP_BIAS;
	endfunction : deriv_shift

	// Legs beyond the populated count read as zero rather than aliasing
	function automatic logic [15:0] pick_leg(
		input logic [NUM_LEGS-1:0][15:0] words,
		input logic [LEG_SEL_W-1:0] sel
	);
		if (32'(sel) < NUM_LEGS) begin
			pick_leg = words[sel];
		end else begin
			pick_leg = 16'h0000;
		end
	endfunction : pick_leg

	// ----------------------------------------
	// Storage: configuration words
	// ----------------------------------------
	logic [15:0] deriv_gain_cfg_reg;
	logic [15:0] deriv_gain_cfg_next;
	logic [15:0] ac_current_feedback_cfg_reg;
	logic [15:0] ac_current_feedback_cfg_next;
	logic [15:0] current_report_scale_reg;
	logic [15:0] current_report_scale_next;

	// ----------------------------------------
	// Storage: command response
	// ----------------------------------------
	logic rsp_valid_reg;
	logic rsp_valid_next;
	loop_gain_regs_pkg::cmd_rsp_t rsp_reg;
	loop_gain_regs_pkg::cmd_rsp_t rsp_next;
	loop_gain_regs_pkg::cmd_rsp_t rsp_load;

	// ----------------------------------------
	// Storage: decoded loop settings
	// ----------------------------------------
	loop_gain_regs_pkg::deriv_gain_t deriv_reg;
	loop_gain_regs_pkg::deriv_gain_t deriv_next;
	logic [7:0] hpf_reg;
	logic [7:0] hpf_next;
	logic [7:0] cfb_reg;
	logic [7:0] cfb_next;
	logic [15:0] scale_reg;
	logic [15:0] scale_next;
	logic [15:0] scaled_reg;
	logic [15:0] scaled_next;

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	wire logic hit_dg = i_cmd.code == loop_gain_regs_pkg::CMD_DERIV_GAIN_CFG;
	wire logic hit_cfb = i_cmd.code == loop_gain_regs_pkg::CMD_AC_CURRENT_FEEDBACK_CFG;
	wire logic hit_scale = i_cmd.code == loop_gain_regs_pkg::CMD_CURRENT_REPORT_SCALE;
	wire logic hit_cur = i_cmd.code == loop_gain_regs_pkg::CMD_LEG_CURRENT_READBACK;
	wire logic hit_temp = i_cmd.code == loop_gain_regs_pkg::CMD_LEG_TEMPERATURE_READBACK;
	wire logic hit_paged = hit_dg | hit_cfb | hit_scale;
	wire logic hit_global = hit_cur | hit_temp;

	// ----------------------------------------
	// Access checks
	// ----------------------------------------
	wire logic page_ok = i_cmd.page == loop_gain_regs_pkg::VALID_PAGE;
	wire logic paged_ok = hit_paged & page_ok;
	wire logic wr_ok = i_cmd_valid & i_cmd.write & paged_ok;
	// Bad page on a paged word, unknown code, or write to a read-only word
	wire logic cmd_bad = ~(paged_ok | (hit_global & ~i_cmd.write));

	// ----------------------------------------
	// Leg selection
	// ----------------------------------------
	wire logic [15:0] sel_current = pick_leg(i_leg_current, i_leg_select);
	wire logic [15:0] sel_temperature = pick_leg(i_leg_temperature, i_leg_select);

	// ----------------------------------------
	// Write enables
	// ----------------------------------------
	wire logic wr_dg = wr_ok & hit_dg;
	wire logic wr_cfb = wr_ok & hit_cfb;
	wire logic wr_scale = wr_ok & hit_scale;

	// ----------------------------------------
	// Register write paths
	// ----------------------------------------
	assign deriv_gain_cfg_next = wr_dg ?
		masked_write(deriv_gain_cfg_reg, i_cmd.data, loop_gain_regs_pkg::DERIV_GAIN_WMASK) :
		deriv_gain_cfg_reg;
	assign ac_current_feedback_cfg_next = wr_cfb ?
		masked_write(ac_current_feedback_cfg_reg, i_cmd.data,
			loop_gain_regs_pkg::FULL_WMASK) :
		ac_current_feedback_cfg_reg;
	assign current_report_scale_next = wr_scale ?
		masked_write(current_report_scale_reg, i_cmd.data,
			loop_gain_regs_pkg::FULL_WMASK) :
		current_report_scale_reg;

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	wire logic [15:0] rd_mux =
		cmd_bad ? 16'h0000 :
		hit_dg ? (deriv_gain_cfg_reg & loop_gain_regs_pkg::DERIV_GAIN_WMASK) :
		hit_cfb ? ac_current_feedback_cfg_reg :
		hit_scale ? current_report_scale_reg :
		hit_cur ? sel_current :
		sel_temperature;

	// ----------------------------------------
	// Response word
	// ----------------------------------------
	assign rsp_next.err = cmd_bad;
	assign rsp_next.data = (i_cmd.write | cmd_bad) ? 16'h0000 : rd_mux;

	// ----------------------------------------
	// Derivative gain decode
	// ----------------------------------------
	wire logic [3:0] dg_mant = deriv_gain_cfg_reg[loop_gain_regs_pkg::DG_MANT_LSB +: 4];
	wire logic [1:0] dg_exp = deriv_gain_cfg_reg[loop_gain_regs_pkg::DG_EXP_LSB +: 2];
	wire logic [3:0] ovr_mant = deriv_gain_cfg_reg[loop_gain_regs_pkg::DG_OVR_MANT_LSB +: 4];
	wire logic [1:0] ovr_exp = deriv_gain_cfg_reg[loop_gain_regs_pkg::DG_OVR_EXP_LSB +: 2];
	wire logic [2:0] p_exp = i_prop_gain_word[loop_gain_regs_pkg::PG_EXP_LSB +: 3];
	wire logic use_ovr = i_one_leg_active & ((ovr_mant != 4'h0) | (ovr_exp != 2'h0));

	// ----------------------------------------
	// Derivative gain selection
	// ----------------------------------------
	assign deriv_next.fir_one_tap = deriv_gain_cfg_reg[loop_gain_regs_pkg::DG_FIR_BIT];
	assign deriv_next.mant = use_ovr ? ovr_mant : dg_mant;
	assign deriv_next.shift = use_ovr ? deriv_shift(ovr_exp, p_exp) :
		deriv_shift(dg_exp, p_exp);

	// ----------------------------------------
	// Current reporting scale
	// ----------------------------------------
	assign scale_next = (current_report_scale_reg == loop_gain_regs_pkg::ZERO_SCALE) ?
		loop_gain_regs_pkg::UNITY_SCALE : current_report_scale_reg;

	// ----------------------------------------
	// Scaled current
	// ----------------------------------------
	wire logic signed [33:0] scale_prod =
		$signed({{18{i_bus_current[15]}}, i_bus_current}) *
		$signed({18'h0, scale_reg});
	wire logic signed [33:0] scale_shr = scale_prod >>> loop_gain_regs_pkg::SCALE_FRAC_BITS;
	// Clamp instead of wrapping so a scale above unity never flips the reported sign
	wire logic too_high = scale_shr > 34'sh7fff;
	wire logic too_low = scale_shr < -34'sh8000;

	assign scaled_next = too_high ? 16'h7fff :
		too_low ? 16'h8000 :
		scale_shr[15:0];

	// ----------------------------------------
	// Register next values
	// ----------------------------------------
	assign rsp_valid_next = i_cmd_valid;
	// The response word stands until the next command is taken
	assign rsp_load = i_cmd_valid ? rsp_next : rsp_reg;
	assign hpf_next = ac_current_feedback_cfg_reg[loop_gain_regs_pkg::CFB_HPF_LSB +: 8];
	assign cfb_next = ac_current_feedback_cfg_reg[loop_gain_regs_pkg::CFB_GAIN_LSB +: 8];

	// ----------------------------------------
	// Configuration words
	// ----------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			deriv_gain_cfg_reg <= loop_gain_regs_pkg::DERIV_GAIN_RESET;
		end else begin
			deriv_gain_cfg_reg <= deriv_gain_cfg_next;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			ac_current_feedback_cfg_reg <= loop_gain_regs_pkg::AC_FEEDBACK_RESET;
		end else begin
			ac_current_feedback_cfg_reg <= ac_current_feedback_cfg_next;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			current_report_scale_reg <= loop_gain_regs_pkg::SCALE_RESET;
		end else begin
			current_report_scale_reg <= current_report_scale_next;
		end
	end

	// ----------------------------------------
	// Command response
	// ----------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			rsp_valid_reg <= 1'b0;
		end else begin
			rsp_valid_reg <= rsp_valid_next;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			rsp_reg <= '0;
		end else begin
			rsp_reg <= rsp_load;
		end
	end

	// ----------------------------------------
	// Decoded loop settings
	// ----------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			deriv_reg <= '0;
		end else begin
			deriv_reg <= deriv_next;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			hpf_reg <= 8'h00;
		end else begin
			hpf_reg <= hpf_next;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			cfb_reg <= 8'h00;
		end else begin
			cfb_reg <= cfb_next;
		end
	end

	// ----------------------------------------
	// Current reporting
	// ----------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			scale_reg <= loop_gain_regs_pkg::SCALE_RESET;
		end else begin
			scale_reg <= scale_next;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			scaled_reg <= 16'h0000;
		end else begin
			scaled_reg <= scaled_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_rsp_valid = rsp_valid_reg;
	assign o_rsp = rsp_reg;
	assign o_deriv_gain = deriv_reg;
	assign o_hpf_coef = hpf_reg;
	assign o_cfb_gain = cfb_reg;
	assign o_scale_factor = scale_reg;
	assign o_scaled_current = scaled_reg;

endmodule : loop_gain_and_leg_telemetry_regs

/* logic/loop_gain_regs_pkg.sv */
// Constants, field layouts and carrier types for the loop gain and leg telemetry registers
package loop_gain_regs_pkg;

	// ----------------------------------------
	// Command codes
	// ----------------------------------------
	localparam logic [7:0] CMD_DERIV_GAIN_CFG = 8'hdf;
	localparam logic [7:0] CMD_AC_CURRENT_FEEDBACK_CFG = 8'he0;
	localparam logic [7:0] CMD_CURRENT_REPORT_SCALE = 8'he3;
	localparam logic [7:0] CMD_LEG_CURRENT_READBACK = 8'he4;
	localparam logic [7:0] CMD_LEG_TEMPERATURE_READBACK = 8'he5;
	localparam logic [7:0] VALID_PAGE = 8'h00;

	// ----------------------------------------
	// Reset values and write masks
	// ----------------------------------------
	localparam logic [15:0] DERIV_GAIN_RESET = 16'h0020;
	localparam logic [15:0] AC_FEEDBACK_RESET = 16'h6840;
	localparam logic [15:0] SCALE_RESET = 16'h4000;
	localparam logic [15:0] DERIV_GAIN_WMASK = 16'h1fff;
	localparam logic [15:0] FULL_WMASK = 16'hffff;
	localparam logic [15:0] UNITY_SCALE = 16'h4000;
	localparam logic [15:0] ZERO_SCALE = 16'h0000;
	localparam int SCALE_FRAC_BITS = 14;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int DG_FIR_BIT = 12;
	localparam int DG_OVR_MANT_LSB = 8;
	localparam int DG_OVR_EXP_LSB = 6;
	localparam int DG_MANT_LSB = 2;
	localparam int DG_EXP_LSB = 0;
	localparam int CFB_HPF_LSB = 8;
	localparam int CFB_GAIN_LSB = 0;
	localparam int PG_EXP_LSB = 0;
	localparam logic signed [4:0] PG_EXP_BIAS = 5'sh03;
	localparam logic signed [4:0] DG_EXP_BIAS = 5'sh01;

	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	typedef struct packed {
		logic write;
		logic [7:0] code;
		logic [7:0] page;
		logic [15:0] data;
	} cmd_req_t;

	typedef struct packed {
		logic err;
		logic [15:0] data;
	} cmd_rsp_t;

	typedef struct packed {
		logic fir_one_tap;
		logic [3:0] mant;
		logic signed [4:0] shift;
	} deriv_gain_t;

endpackage : loop_gain_regs_pkg

/* test/loop_gain_regs_sva.sv */
// Port checks for the loop gain and leg telemetry registers
`timescale 1ns/1ps
module loop_gain_regs_sva #(
	parameter int NUM_LEGS = 4,
	parameter int LEG_SEL_W = 2
) (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_cmd_valid,
	input wire loop_gain_regs_pkg::cmd_req_t i_cmd,
	input wire logic [LEG_SEL_W-1:0] i_leg_select,
	input wire logic [NUM_LEGS-1:0][15:0] i_leg_current,
	input wire logic [NUM_LEGS-1:0][15:0] i_leg_temperature,
	input wire logic o_rsp_valid,
	input wire loop_gain_regs_pkg::cmd_rsp_t o_rsp,
	input wire logic [7:0] o_hpf_coef,
	input wire logic [7:0] o_cfb_gain,
	input wire logic [15:0] o_scale_factor
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_reset);
	logic [15:0] wdata_d, cur_d, tmp_d;
	wire logic rd = i_cmd_valid && !i_cmd.write;
	wire logic wr_ok = i_cmd_valid && i_cmd.write && i_cmd.page == 8'h00;
	wire logic paged = i_cmd.code inside {8'hdf, 8'he0, 8'he3};
	always_ff @(posedge i_sys_clk) begin
		wdata_d <= i_cmd.data;
		cur_d <= i_leg_current[i_leg_select];
		tmp_d <= i_leg_temperature[i_leg_select];
	end
	a_rsp_one_cycle: assert property (i_cmd_valid |=> o_rsp_valid)
		else $error("no response one cycle after a command");
	a_rsp_no_spur: assert property (!i_cmd_valid |=> !o_rsp_valid)
		else $error("response without a command");
	a_page_refused: assert property (i_cmd_valid && paged && i_cmd.page != 8'h00
		|=> o_rsp.err && o_rsp.data == 16'h0000) else $error("bad page accepted");
	a_ro_write_err: assert property (i_cmd_valid && i_cmd.write
		&& i_cmd.code inside {8'he4, 8'he5} |=> o_rsp.err) else $error("read-only write taken");
	a_leg_current_rd: assert property (rd && i_cmd.code == 8'he4
		|=> !o_rsp.err && o_rsp.data == cur_d) else $error("leg current read wrong");
	a_leg_temp_rd: assert property (rd && i_cmd.code == 8'he5
		|=> !o_rsp.err && o_rsp.data == tmp_d) else $error("leg temperature read wrong");
	a_reserved_bits_zero: assert property (rd && i_cmd.code == 8'hdf && i_cmd.page == 8'h00
		|=> o_rsp.data[15:13] == 3'h0) else $error("reserved bits not zero");
	a_cfb_fields: assert property (wr_ok && i_cmd.code == 8'he0
		|=> ##1 {o_hpf_coef, o_cfb_gain} == $past(wdata_d)) else $error("feedback fields stale");
	a_scale_zero_unity: assert property (wr_ok && i_cmd.code == 8'he3
		&& i_cmd.data == 16'h0000
		|=> ##1 o_scale_factor == 16'h4000) else $error("zero scale not unity");
	a_scale_follow: assert property (wr_ok && i_cmd.code == 8'he3 && i_cmd.data != 16'h0000
		|=> ##1 o_scale_factor == $past(wdata_d)) else $error("scale not applied");
endmodule : loop_gain_regs_sva

/* test/pmbus_host_model.sv */
// Host model issuing decoded read-word and write-word commands
`timescale 1ns/1ps
module pmbus_host_model (
	input wire logic i_sys_clk,
	input wire logic i_rsp_valid,
	input wire loop_gain_regs_pkg::cmd_rsp_t i_rsp,
	output logic o_cmd_valid,
	output loop_gain_regs_pkg::cmd_req_t o_cmd
);
	initial begin
		o_cmd_valid = 1'b0;
		o_cmd = '0;
	end
	// One whole word per command; answer is sampled 1 ns after the taking edge
	task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] page,
		input logic [15:0] data, output loop_gain_regs_pkg::cmd_rsp_t rsp, output logic ok);
		@(posedge i_sys_clk);
		#1;
		o_cmd_valid = 1'b1;
		o_cmd = {wr, code, page, data};
		@(posedge i_sys_clk);
		#1;
		o_cmd_valid = 1'b0;
		o_cmd = ~o_cmd;
		ok = i_rsp_valid;
		rsp = i_rsp;
	endtask : xfer
endmodule : pmbus_host_model

/* test/testbench.sv */
// Self-checking bench for the loop gain and leg telemetry registers
`timescale 1ns/1ps
module testbench;
	logic i_sys_clk = 1'b0;
	logic i_reset = 1'b1;
	logic cmd_valid, rsp_valid, one_leg;
	loop_gain_regs_pkg::cmd_req_t cmd;
	loop_gain_regs_pkg::cmd_rsp_t rsp;
	loop_gain_regs_pkg::deriv_gain_t dg;
	logic [1:0] leg_sel = 2'h0;
	logic [3:0][15:0] leg_cur = {16'hff03, 16'hff02, 16'hff01, 16'hff00};
	logic [3:0][15:0] leg_tmp = {16'h0f03, 16'h0f02, 16'h0f01, 16'h0f00};
	logic [15:0] prop = 16'h89c4;
	logic [15:0] bus_cur = 16'h0100;
	logic [7:0] hpf, cfb;
	logic [15:0] sf, scur;
	int checked = 0;
	int fail_count = 0;
	loop_gain_and_leg_telemetry_regs loop_gain_and_leg_telemetry_regs_i (.i_sys_clk(i_sys_clk),
		.i_reset(i_reset), .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_leg_select(leg_sel),
		.i_leg_current(leg_cur), .i_leg_temperature(leg_tmp), .i_prop_gain_word(prop),
		.i_one_leg_active(one_leg), .i_bus_current(bus_cur), .o_rsp_valid(rsp_valid), .o_rsp(rsp),
		.o_deriv_gain(dg), .o_hpf_coef(hpf), .o_cfb_gain(cfb), .o_scale_factor(sf),
		.o_scaled_current(scur));
	pmbus_host_model pmbus_host_model_i (.i_sys_clk(i_sys_clk), .i_rsp_valid(rsp_valid),
		.i_rsp(rsp), .o_cmd_valid(cmd_valid), .o_cmd(cmd));
	initial forever #50 i_sys_clk = ~i_sys_clk;
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : close_out
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic op(input logic wr, input logic [7:0] code, input logic [7:0] page,
		input logic [15:0] data, input logic err, input logic [15:0] exp);
		loop_gain_regs_pkg::cmd_rsp_t r;
		logic ok;
		pmbus_host_model_i.xfer(wr, code, page, data, r, ok);
		check({15'h0000, ok}, 16'h0001);
		check({15'h0000, r.err}, {15'h0000, err});
		check(r.data, exp);
	endtask : op
	task automatic settle(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask : settle
	task automatic t_reset();
		op(0, 8'hdf, 8'h00, 16'h0000, 0, 16'h0020);
		op(0, 8'he0, 8'h00, 16'h0000, 0, 16'h6840);
		op(0, 8'he3, 8'h00, 16'h0000, 0, 16'h4000);
		$display("reset values done");
	endtask : t_reset
	task automatic t_deriv();
		op(1, 8'hdf, 8'h00, 16'hfb8d, 0, 16'h0000);
		op(0, 8'hdf, 8'h00, 16'h0000, 0, 16'h1b8d);
		settle(2);
		check({6'h00, dg}, {6'h00, 1'b1, 4'h3, 5'h03});
		one_leg = 1'b1;
		settle(2);
		check({6'h00, dg}, {6'h00, 1'b1, 4'hb, 5'h04});
		op(1, 8'hdf, 8'h00, 16'h1011, 0, 16'h0000);
		settle(2);
		check({6'h00, dg}, {6'h00, 1'b1, 4'h4, 5'h03});
		$display("derivative gain done");
	endtask : t_deriv
	task automatic t_feedback();
		op(1, 8'he0, 8'h00, 16'h1234, 0, 16'h0000);
		settle(2);
		check({hpf, cfb}, 16'h1234);
		op(1, 8'he0, 8'h01, 16'h5678, 1, 16'h0000);
		op(0, 8'he0, 8'h00, 16'h0000, 0, 16'h1234);
		$display("feedback done");
	endtask : t_feedback
	task automatic t_scale();
		op(1, 8'he3, 8'h00, 16'h0000, 0, 16'h0000);
		op(0, 8'he3, 8'h00, 16'h0000, 0, 16'h0000);
		settle(3);
		check(sf, 16'h4000);
		check(scur, 16'h0100);
		op(1, 8'he3, 8'h00, 16'h8000, 0, 16'h0000);
		settle(3);
		check(scur, 16'h0200);
		$display("scale done");
	endtask : t_scale
	task automatic t_legs();
		for (int k = 0; k < 4; k++) begin
			leg_sel = 2'(k);
			op(0, 8'he4, 8'h00, 16'h0000, 0, 16'hff00 + 16'(k));
			op(0, 8'he5, 8'h00, 16'h0000, 0, 16'h0f00 + 16'(k));
		end
		op(1, 8'he4, 8'h00, 16'h0001, 1, 16'h0000);
		op(1, 8'he5, 8'h00, 16'h0001, 1, 16'h0000);
		op(0, 8'h42, 8'h00, 16'h0000, 1, 16'h0000);
		$display("legs done");
	endtask : t_legs
	task automatic t_midreset();
		op(1, 8'he0, 8'h00, 16'hbeef, 0, 16'h0000);
		i_reset = 1'b1;
		settle(2);
		i_reset = 1'b0;
		check({hpf, cfb}, 16'h0000);
		check({6'h00, dg}, 16'h0000);
		check(sf, 16'h4000);
		op(0, 8'he0, 8'h00, 16'h0000, 0, 16'h6840);
		op(0, 8'hdf, 8'h00, 16'h0000, 0, 16'h0020);
		op(0, 8'he3, 8'h00, 16'h0000, 0, 16'h4000);
		$display("mid-run reset done");
	endtask : t_midreset
	initial begin
		one_leg = 1'b0;
		repeat (2) @(posedge i_sys_clk);
		#1;
		i_reset = 1'b0;
		t_reset();
		t_deriv();
		t_feedback();
		t_scale();
		t_legs();
		t_midreset();
		close_out();
	end
	initial begin
		#(2000 * 100);
		fail_count++;
		close_out();
	end
endmodule : testbench
bind loop_gain_and_leg_telemetry_regs loop_gain_regs_sva #(.NUM_LEGS(NUM_LEGS),
	.LEG_SEL_W(LEG_SEL_W)) chk_i (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
	.i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_leg_select(i_leg_select),
	.i_leg_current(i_leg_current), .i_leg_temperature(i_leg_temperature),
	.o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp), .o_hpf_coef(o_hpf_coef),
	.o_cfb_gain(o_cfb_gain), .o_scale_factor(o_scale_factor));
